// *** include/ddc_pkg.sv ***
// shared constants and carrier types of the dual dac command decoder
package ddc_pkg;

  // ------------------------------------------------------------------
  // serial word layout
  // ------------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int DATA_W = 16;
  localparam logic [4:0] BITS_PER_FRAME = 5'd24;
  localparam logic [4:0] BIT_CNT_SAT = 5'd25;
  localparam logic [7:0] RB_HDR = 8'h00;

  // register select codes
  localparam logic [2:0] REG_FUNC = 3'h0;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_COARSE = 3'h3;
  localparam logic [2:0] REG_FINE = 3'h4;
  localparam logic [2:0] REG_OFFSET = 3'h5;

  // channel select codes
  localparam logic [2:0] CH_A = 3'h0;
  localparam logic [2:0] CH_B = 3'h1;
  localparam logic [2:0] CH_BOTH = 3'h4;

  // function register operations, carried in the channel field
  localparam logic [2:0] FN_NOP = 3'h0;
  localparam logic [2:0] FN_CTRL = 3'h1;
  localparam logic [2:0] FN_CLEAR = 3'h4;
  localparam logic [2:0] FN_LOAD = 3'h5;

  // ------------------------------------------------------------------
  // control field positions and reset values
  // ------------------------------------------------------------------
  localparam int CTL_SDO_DIS = 0;
  localparam int CTL_GP0_VAL = 1;
  localparam int CTL_GP0_DIR = 2;
  localparam int CTL_GP1_VAL = 3;
  localparam int CTL_GP1_DIR = 4;
  localparam int CTL_LGO = 5;
  localparam int CTL_W = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [15:0] CLEAR_CODE = 16'h0000;
  localparam logic [1:0] BOOT_WAIT = 2'h3;

  typedef struct packed {
    logic rd;
    logic zero;
    logic [2:0] regsel;
    logic [2:0] chsel;
    logic [15:0] data;
  } ddc_cmd_t;

  typedef struct packed {
    logic [1:0] coarse;
    logic [5:0] fine;
    logic [7:0] offset;
  } ddc_chan_cfg_t;

  localparam ddc_chan_cfg_t CFG_RESET = 16'h0000;

  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic sdin;
    logic load_strobe_n_n;
    logic clr_n;
    logic gp1;
    logic gp0;
  } ddc_pins_t;

  // idle levels the pin synchroniser resets to, so no false edge is seen
  localparam ddc_pins_t PINS_IDLE = 7'h6C;

endpackage : ddc_pkg

// *** rtl/ddc_sync.sv ***
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module ddc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : ddc_sync
`default_nettype wire

// *** rtl/ddc_core.sv ***
// serial command decoder and control logic of a dual 16-bit dac
`timescale 1ns/1ps
`default_nettype none
module ddc_core (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic serial_in,
  input wire logic load_strobe_n,
  input wire logic async_clear_n,
  input wire logic gp_pin_zero_i,
  input wire logic gp_pin_one_i,
  output logic gp_pin_zero_o,
  output logic gp_pin_zero_oe,
  output logic gp_pin_one_o,
  output logic gp_pin_one_oe,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  output logic lgo_enable,
  output logic [15:0] dac_code_a,
  output logic [15:0] dac_code_b,
  output ddc_pkg::ddc_chan_cfg_t chan_cfg_a,
  output ddc_pkg::ddc_chan_cfg_t chan_cfg_b
);
  import ddc_pkg::*;

  // ------------------------------------------------------------------
  // pin synchronisation and edge detection
  // ------------------------------------------------------------------
  ddc_pins_t pin_raw;
  ddc_pins_t pin_s;
  ddc_pins_t pin_d_r;

  assign pin_raw = {sclk, frame_sync_n, serial_in, load_strobe_n,
                    async_clear_n, gp_pin_one_i, gp_pin_zero_i};

  ddc_sync #(.W($bits(ddc_pins_t)), .RST_VAL(PINS_IDLE)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d(pin_raw),
    .q(pin_s)
  );

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pin_d_r <= PINS_IDLE;
    else
      pin_d_r <= pin_s;
  end

  logic sclk_fall, sclk_rise, frame_start, frame_end, clr_fall, load_strobe_n_fall;
  assign sclk_fall = pin_d_r.sclk & ~pin_s.sclk;
  assign sclk_rise = ~pin_d_r.sclk & pin_s.sclk;
  assign frame_start = pin_d_r.sync_n & ~pin_s.sync_n;
  assign frame_end = ~pin_d_r.sync_n & pin_s.sync_n;
  assign clr_fall = pin_d_r.clr_n & ~pin_s.clr_n;
  assign load_strobe_n_fall = pin_d_r.load_strobe_n_n & ~pin_s.load_strobe_n_n;

  // ------------------------------------------------------------------
  // frame sequencing
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_SHIFT} ddc_state_t;
  ddc_state_t state_r;
  logic [1:0] boot_cnt_r;
  logic boot_done;

  // edges are ignored until the synchroniser has seen real pin levels
  assign boot_done = (state_r == ST_BOOT) && (boot_cnt_r == BOOT_WAIT);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_BOOT;
      boot_cnt_r <= '0;
    end
    else
    begin
      unique case (state_r)
        ST_BOOT:
        begin
          boot_cnt_r <= boot_cnt_r + 2'h1;
          if (boot_done)
            state_r <= ST_IDLE;
        end
        ST_IDLE:
          if (frame_start)
            state_r <= ST_SHIFT;
        ST_SHIFT:
          if (frame_end)
            state_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // shift register, bit count and serial data out
  // ------------------------------------------------------------------
  logic [WORD_W-1:0] shift_r;
  logic [4:0] bit_cnt_r;
  logic sdo_r;
  logic read_pend_r;
  logic [2:0] rd_regsel_r, rd_chsel_r;
  logic [CTL_W-1:0] ctrl_r;
  logic [15:0] in_a_r, in_b_r;
  ddc_chan_cfg_t cfg_a_r, cfg_b_r;
  logic [15:0] rb_data;
  logic [CTL_W-1:0] ctrl_view;
  ddc_chan_cfg_t rb_cfg;
  logic [WORD_W-1:0] load_word;
  logic rb_chan_b;

  // input pins replace the gp value bits on readback
  always_comb
  begin
    ctrl_view = ctrl_r;
    if (!ctrl_r[CTL_GP0_DIR])
      ctrl_view[CTL_GP0_VAL] = pin_s.gp0;
    if (!ctrl_r[CTL_GP1_DIR])
      ctrl_view[CTL_GP1_VAL] = pin_s.gp1;
  end

  assign rb_chan_b = (rd_chsel_r == CH_B);
  assign rb_cfg = rb_chan_b ? cfg_b_r : cfg_a_r;

  always_comb
  begin
    unique case (rd_regsel_r)
      REG_FUNC: rb_data = {{(DATA_W - CTL_W){1'b0}}, ctrl_view};
      REG_DATA: rb_data = rb_chan_b ? in_b_r : in_a_r;
      REG_COARSE: rb_data = {14'h0000, rb_cfg.coarse};
      REG_FINE: rb_data = {10'h000, rb_cfg.fine};
      REG_OFFSET: rb_data = {8'h00, rb_cfg.offset};
      default: rb_data = '0;
    endcase
  end

  assign load_word = read_pend_r ? {RB_HDR, rb_data} : shift_r;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_r <= '0;
      bit_cnt_r <= '0;
      sdo_r <= 1'b0;
    end
    else if (state_r == ST_IDLE && frame_start)
    begin
      shift_r <= load_word;
      bit_cnt_r <= '0;
      sdo_r <= load_word[WORD_W-1];
    end
    else if (state_r == ST_SHIFT)
    begin
      // extra clocks ripple the word out for daisy chaining
      if (sclk_fall)
      begin
        shift_r <= {shift_r[WORD_W-2:0], pin_s.sdin};
        if (bit_cnt_r != BIT_CNT_SAT)
          bit_cnt_r <= bit_cnt_r + 5'h01;
      end
      if (sclk_rise)
        sdo_r <= shift_r[WORD_W-1];
    end
  end

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  ddc_cmd_t cmd;
  logic word_ok, wr, fn_wr, hit_a, hit_b, clear_evt, load_all;
  logic ctrl_wr, data_wr, now_load;

  assign cmd = shift_r;
  // a short or long frame is dropped whole
  assign word_ok = (state_r == ST_SHIFT) && frame_end &&
                   (bit_cnt_r == BITS_PER_FRAME);
  assign wr = word_ok && !cmd.rd;
  assign fn_wr = wr && (cmd.regsel == REG_FUNC);
  assign hit_a = (cmd.chsel == CH_A) || (cmd.chsel == CH_BOTH);
  assign hit_b = (cmd.chsel == CH_B) || (cmd.chsel == CH_BOTH);
  assign ctrl_wr = fn_wr && (cmd.chsel == FN_CTRL);
  assign data_wr = wr && (cmd.regsel == REG_DATA);
  assign now_load = !pin_s.load_strobe_n_n;
  assign clear_evt = (clr_fall && state_r != ST_BOOT) ||
                     (boot_done && !pin_s.clr_n) ||
                     (fn_wr && cmd.chsel == FN_CLEAR);
  assign load_all = (load_strobe_n_fall && state_r != ST_BOOT) ||
                    (fn_wr && cmd.chsel == FN_LOAD);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      read_pend_r <= 1'b0;
      rd_regsel_r <= REG_FUNC;
      rd_chsel_r <= CH_A;
    end
    else if (word_ok)
    begin
      read_pend_r <= cmd.rd;
      rd_regsel_r <= cmd.regsel;
      rd_chsel_r <= cmd.chsel;
    end
    else if (state_r == ST_IDLE && frame_start)
      read_pend_r <= 1'b0;
  end

  // ------------------------------------------------------------------
  // function control register
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_r <= CTRL_RESET;
    else if (ctrl_wr)
    begin
      ctrl_r[CTL_LGO] <= cmd.data[CTL_LGO];
      ctrl_r[CTL_GP1_DIR] <= cmd.data[CTL_GP1_DIR];
      ctrl_r[CTL_GP0_DIR] <= cmd.data[CTL_GP0_DIR];
      ctrl_r[CTL_SDO_DIS] <= cmd.data[CTL_SDO_DIS];
      // written values only stick on pins set as outputs
      if (cmd.data[CTL_GP1_DIR])
        ctrl_r[CTL_GP1_VAL] <= cmd.data[CTL_GP1_VAL];
      if (cmd.data[CTL_GP0_DIR])
        ctrl_r[CTL_GP0_VAL] <= cmd.data[CTL_GP0_VAL];
    end
  end

  logic sdo_oe_r;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      sdo_oe_r <= ~CTRL_RESET[CTL_SDO_DIS];
    else if (ctrl_wr)
      sdo_oe_r <= ~cmd.data[CTL_SDO_DIS];
  end

  // ------------------------------------------------------------------
  // channel registers and dac codes
  // ------------------------------------------------------------------
  logic [15:0] dac_a_r, dac_b_r;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_a_r <= CFG_RESET;
      cfg_b_r <= CFG_RESET;
    end
    else if (wr)
    begin
      unique case (cmd.regsel)
        REG_COARSE:
        begin
          if (hit_a) cfg_a_r.coarse <= cmd.data[1:0];
          if (hit_b) cfg_b_r.coarse <= cmd.data[1:0];
        end
        REG_FINE:
        begin
          if (hit_a) cfg_a_r.fine <= cmd.data[5:0];
          if (hit_b) cfg_b_r.fine <= cmd.data[5:0];
        end
        REG_OFFSET:
        begin
          if (hit_a) cfg_a_r.offset <= cmd.data[7:0];
          if (hit_b) cfg_b_r.offset <= cmd.data[7:0];
        end
        default: ;
      endcase
    end
  end

  // clear wins over any write or load in the same cycle; the clear code
  // happens to be all zero under both codings, so no coding pin is read
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_a_r <= CLEAR_CODE;
      in_b_r <= CLEAR_CODE;
      dac_a_r <= CLEAR_CODE;
      dac_b_r <= CLEAR_CODE;
    end
    else if (clear_evt)
    begin
      in_a_r <= CLEAR_CODE;
      in_b_r <= CLEAR_CODE;
      dac_a_r <= CLEAR_CODE;
      dac_b_r <= CLEAR_CODE;
    end
    else
    begin
      if (load_all)
      begin
        dac_a_r <= in_a_r;
        dac_b_r <= in_b_r;
      end
      if (data_wr && hit_a)
      begin
        in_a_r <= cmd.data;
        if (now_load) dac_a_r <= cmd.data;
      end
      if (data_wr && hit_b)
      begin
        in_b_r <= cmd.data;
        if (now_load) dac_b_r <= cmd.data;
      end
    end
  end

  assign dac_code_a = dac_a_r;
  assign dac_code_b = dac_b_r;
  assign chan_cfg_a = cfg_a_r;
  assign chan_cfg_b = cfg_b_r;
  assign lgo_enable = ctrl_r[CTL_LGO];
  assign gp_pin_zero_o = ctrl_r[CTL_GP0_VAL];
  assign gp_pin_zero_oe = ctrl_r[CTL_GP0_DIR];
  assign gp_pin_one_o = ctrl_r[CTL_GP1_VAL];
  assign gp_pin_one_oe = ctrl_r[CTL_GP1_DIR];
  assign serial_out_pin_o = sdo_r;
  assign serial_out_pin_oe = sdo_oe_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence seq_fn_op(logic [2:0] op);
    fn_wr && cmd.chsel == op;
  endsequence
  sequence seq_cleared;
    dac_a_r == CLEAR_CODE && dac_b_r == CLEAR_CODE;
  endsequence

  a_pin_clear: assert property (
    clr_fall && state_r != ST_BOOT |=> seq_cleared)
    else $error("clear pin edge did not clear outputs");
  a_hold_value: assert property (
    !clear_evt && !load_all && !(data_wr && now_load) |=> $stable(dac_a_r))
    else $error("dac code changed without cause");
  a_boot_clear: assert property (
    boot_done && !pin_s.clr_n |=> seq_cleared)
    else $error("power-up clear missed");
  a_soft_clear: assert property (
    seq_fn_op(FN_CLEAR) |=> seq_cleared)
    else $error("software clear did not clear outputs");
  a_ctrl_write: assert property (
    seq_fn_op(FN_CTRL) |=> lgo_enable == $past(cmd.data[CTL_LGO]) &&
    gp_pin_one_oe == $past(cmd.data[CTL_GP1_DIR]))
    else $error("control write not applied");
  a_gp_input_val: assert property (
    seq_fn_op(FN_CTRL) ##0 !cmd.data[CTL_GP0_DIR]
    |=> $stable(gp_pin_zero_o))
    else $error("input pin value bit was overwritten");
  a_nop_idle: assert property (
    seq_fn_op(FN_NOP) |=> $stable(ctrl_r))
    else $error("no-op changed control bits");
  a_sdo_enable: assert property (
    serial_out_pin_oe == !ctrl_r[CTL_SDO_DIS])
    else $error("serial out enable disagrees with disable bit");
  a_soft_load: assert property (
    seq_fn_op(FN_LOAD) |=> dac_a_r == $past(in_a_r) &&
    dac_b_r == $past(in_b_r))
    else $error("load command did not update outputs");
  a_bad_frame: assert property (
    frame_end && bit_cnt_r != BITS_PER_FRAME && !clear_evt &&
    !load_all |=> $stable(in_a_r) && $stable(ctrl_r))
    else $error("frame of wrong length was taken");
  // marks a taken read until the next frame picks up its answer
  logic rb_armed_r;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rb_armed_r <= 1'b0;
    else if (word_ok && cmd.rd)
      rb_armed_r <= 1'b1;
    else if (state_r == ST_IDLE && frame_start)
      rb_armed_r <= 1'b0;
  end

  sequence seq_rb_start;
    rb_armed_r && state_r == ST_IDLE && frame_start;
  endsequence

  a_readback: assert property (
    seq_rb_start |=> shift_r == {RB_HDR, $past(rb_data)})
    else $error("readback word not loaded at next frame");
  a_load_strobe_n_update: assert property (
    load_strobe_n_fall && state_r != ST_BOOT && !clear_evt && !data_wr
    |=> dac_b_r == $past(in_b_r))
    else $error("load strobe fall did not update outputs");
  a_both_chan: assert property (
    data_wr && cmd.chsel == CH_BOTH && !clear_evt |=> in_a_r == in_b_r)
    else $error("both-channel write differs between channels");
endmodule : ddc_core
`default_nettype wire

// *** sim/ddc_host_model.sv ***
// host serial port model that sends command frames to the decoder
`timescale 1ns/1ps
`default_nettype none
module ddc_host_model (
  input wire logic ref_clk,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe,
  output var logic sclk,
  output var logic frame_sync_n,
  output var logic serial_in
);
  // link clock stands high between frames
  initial
  begin
    sclk = 1'b1;
    frame_sync_n = 1'b1;
    serial_in = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // ------------------------------------------------------------------
  // one frame of nb bits, msb first, with the word that comes back
  // ------------------------------------------------------------------
  task automatic xfer(input logic [23:0] w, input int nb,
                      output logic [23:0] rd);
    logic [23:0] sh;
    sh = w;
    rd = 24'h000000;
    frame_sync_n = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      serial_in = sh[23];
      sh = {sh[22:0], sh[23]};
      tick(5);
      // a released output reads inverted so a stale bit never matches
      rd = {rd[22:0], serial_out_pin_oe ? serial_out_pin_o : ~rd[0]};
      sclk = 1'b0;
      tick(3);
      sclk = 1'b1;
    end
    tick(2);
    frame_sync_n = 1'b1;
    serial_in = ~serial_in;
    tick(8);
  endtask : xfer
endmodule : ddc_host_model
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench of the dual dac command decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ddc_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic load_strobe_n = 1'b0;
  logic async_clear_n = 1'b0;
  logic gp0_ext = 1'b1;
  logic gp1_ext = 1'b0;
  wire logic sclk, frame_sync_n, serial_in, gp0_line, gp1_line;
  wire logic gp0_o, gp0_oe, gp1_o, gp1_oe, serial_out_pin, sdo_oe, lgo_enable;
  wire logic [15:0] code_a, code_b;
  wire ddc_chan_cfg_t cfg_a, cfg_b;
  int n_errors = 0;
  int total_checks = 0;
  logic [23:0] rd;
  logic [31:0] ctl_bits;

  assign ctl_bits = {26'h0, lgo_enable, gp1_oe, gp1_o, gp0_oe, gp0_o, sdo_oe};

  always #25 ref_clk = ~ref_clk;

  // the device wins the pin while it drives, else the outside level
  assign gp0_line = gp0_oe ? gp0_o : gp0_ext;
  assign gp1_line = gp1_oe ? gp1_o : gp1_ext;

  ddc_host_model host (
    .ref_clk(ref_clk),
    .serial_out_pin_o(serial_out_pin),
    .serial_out_pin_oe(sdo_oe),
    .sclk(sclk),
    .frame_sync_n(frame_sync_n),
    .serial_in(serial_in)
  );

  ddc_core DUT (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sclk(sclk),
    .frame_sync_n(frame_sync_n),
    .serial_in(serial_in),
    .load_strobe_n(load_strobe_n),
    .async_clear_n(async_clear_n),
    .gp_pin_zero_i(gp0_line),
    .gp_pin_one_i(gp1_line),
    .gp_pin_zero_o(gp0_o),
    .gp_pin_zero_oe(gp0_oe),
    .gp_pin_one_o(gp1_o),
    .gp_pin_one_oe(gp1_oe),
    .serial_out_pin_o(serial_out_pin),
    .serial_out_pin_oe(sdo_oe),
    .lgo_enable(lgo_enable),
    .dac_code_a(code_a),
    .dac_code_b(code_b),
    .chan_cfg_a(cfg_a),
    .chan_cfg_b(cfg_b)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [23:0] w);
    host.xfer(w, 24, rd);
  endtask : wr

  task automatic wait_codes(input logic [31:0] exp);
    int k;
    k = 0;
    while (k < 10 && {code_a, code_b} !== exp)
    begin
      cyc(1);
      k++;
    end
    chk({code_a, code_b}, exp);
  endtask : wait_codes

  task automatic close_out();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    close_out();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    cyc(10);
    async_clear_n = 1'b1;
    cyc(6);
    chk({code_a, code_b}, 32'h0);
    chk(ctl_bits, 32'h1);
    wr(24'h10_1234);
    chk({code_a, code_b}, 32'h1234_0000);
    wr(24'h11_ABCD);
    chk({code_a, code_b}, 32'h1234_ABCD);
    wr(24'h14_5A5A);
    chk({code_a, code_b}, 32'h5A5A_5A5A);
    // short and long frames must leave everything alone
    host.xfer(24'h10_FFFF, 23, rd);
    chk({code_a, code_b}, 32'h5A5A_5A5A);
    host.xfer(24'h10_FFFF, 25, rd);
    chk({code_a, code_b}, 32'h5A5A_5A5A);
    wr(24'h18_FFFE);
    wr(24'h21_FF2A);
    wr(24'h2C_FFD8);
    chk({cfg_a, cfg_b}, 32'h80D8_2AD8);
    chk({code_a, code_b}, 32'h5A5A_5A5A);
    // deferred update through the load strobe and the load command
    load_strobe_n = 1'b1;
    wr(24'h10_5555);
    wr(24'h11_7777);
    chk({code_a, code_b}, 32'h5A5A_5A5A);
    load_strobe_n = 1'b0;
    wait_codes(32'h5555_7777);
    load_strobe_n = 1'b1;
    wr(24'h10_0101);
    wr(24'h00_FFFF);
    chk({code_a, code_b}, 32'h5555_7777);
    wr(24'h05_0000);
    chk({code_a, code_b}, 32'h0101_7777);
    load_strobe_n = 1'b0;
    cyc(6);
    // clear pin, then software clear
    async_clear_n = 1'b0;
    cyc(6);
    chk({code_a, code_b}, 32'h0);
    async_clear_n = 1'b1;
    cyc(10);
    chk({code_a, code_b}, 32'h0);
    wr(24'h10_4321);
    chk({code_a, code_b}, 32'h4321_0000);
    wr(24'h04_9999);
    chk({code_a, code_b}, 32'h0);
    // control bits, general purpose pins and register readback
    wr(24'h01_003C);
    chk(ctl_bits, 32'h3D);
    wr(24'h01_0002);
    chk(ctl_bits, 32'h09);
    wr(24'h81_0000);
    wr(24'h00_0000);
    chk({8'h00, rd}, {8'h00, RB_HDR, 16'h0002});
    wr(24'h11_C3A5);
    wr(24'h91_0000);
    wr(24'h00_0000);
    chk({8'h00, rd}, {8'h00, RB_HDR, 16'hC3A5});
    chk({code_a, code_b}, 32'h0000_C3A5);
    wr(24'hA1_0000);
    wr(24'h00_0000);
    chk({8'h00, rd}, {8'h00, RB_HDR, 16'h002A});
    wr(24'h01_0001);
    chk({31'h0, sdo_oe}, 32'h0);
    wr(24'h01_0000);
    chk({31'h0, sdo_oe}, 32'h1);
    close_out();
  end
endmodule : tb
`default_nettype wire
